// file: rtl/aprc_ctrl.v
// reset, status and control logic of the four-channel pwm audio processor
// assumes clk is the master clock; pins arrive asynchronous to it
`timescale 1ns/1ps
`include "aprc_map.vh"
module aprc_ctrl #(
  parameter [6:0] I2C_ADDR = 7'h1B,
  // arbitrary identification value
  parameter [3:0] DEVICE_ID = 4'h5
) (
  input wire clk,
  input wire ce,
  input wire srst,
  input wire resetN,
  input wire pllLock,
  input wire lrclkPin,
  input wire sclkPin,
  input wire sclPin,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  input wire clipEvent,
  input wire [3:0] coreP,
  input wire [3:0] coreM,
  input wire [95:0] sampleIn,
  input wire sampleStrobe,
  output wire [95:0] sampleOut,
  output reg sampleValid,
  output reg valid,
  output reg [3:0] pwmP,
  output reg [3:0] pwmM,
  output reg supplyPwm,
  output reg [7:0] masterVol,
  output wire [31:0] chanVol,
  output wire dcBlockEn,
  output wire [1:0] deemphSel,
  output wire [2:0] modLimit,
  output wire [1:0] supplyRange,
  output wire amEnable,
  output wire [7:0] amCtrl,
  output wire [15:0] amTuned,
  output wire [7:0] serialFormat,
  output wire [7:0] rateCtrl,
  output wire [7:0] toneIndex,
  output wire [7:0] toneSets,
  output reg [2:0] sampleRate
);
  localparam S_RESET = 3'd0;
  localparam S_DETECT = 3'd1;
  localparam S_INIT = 3'd2;
  localparam S_MUTED = 3'd3;
  localparam S_START = 3'd4;
  localparam S_RUN = 3'd5;
  localparam I_IDLE = 3'd0;
  localparam I_ADDR = 3'd1;
  localparam I_SUB = 3'd2;
  localparam I_WR = 3'd3;
  localparam I_RD = 3'd4;
  localparam integer INIT_CYC_N = `APRC_INIT_CYC;
  localparam integer START_CYC_N = `APRC_START_CYC;
  localparam [15:0] INIT_CYC = INIT_CYC_N[15:0];
  localparam [15:0] START_CYC = START_CYC_N[15:0];

  reg [1:0] rstSync;
  reg [4:0] syncA;
  reg [4:0] syncB;
  reg [4:0] pinPrev;
  reg [7:0] cfg [3:16];
  reg [2:0] iSt;
  reg [3:0] iBit;
  reg [7:0] iSh;
  reg [7:0] iSub;
  reg [7:0] iTx;
  reg iAck;
  reg sdaDrive;
  reg wrEn;
  reg [7:0] wrAddr;
  reg [7:0] wrData;
  reg clipFlag;
  reg errLr;
  reg errSck;
  reg errSlip;
  reg errPll;
  reg [11:0] perCnt;
  reg [11:0] perPrev;
  reg [7:0] bitsCnt;
  reg [1:0] frameCnt;
  reg rateKnown;
  reg [2:0] st;
  reg [2:0] next_st;
  reg [15:0] stCnt;
  reg recov;
  reg [7:0] pwmCnt;
  integer i;

  // release is synchronised so every control leaves reset on one edge
  always @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      rstSync <= 2'b00;
    end else if (ce) begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  wire chipRst = srst | ~rstSync[1];

  // pins: pll lock, frame clock, bit clock, scl, sda
  always @(posedge clk) begin
    if (ce) begin
      syncA <= {pllLock, lrclkPin, sclkPin, sclPin, sdaIn};
      syncB <= syncA;
      pinPrev <= syncB;
    end
  end
  wire lrRise = syncB[3] & ~pinPrev[3];
  wire sckRise = syncB[2] & ~pinPrev[2];
  wire sclRise = syncB[1] & ~pinPrev[1];
  wire sclFall = ~syncB[1] & pinPrev[1];
  wire sdaNow = syncB[0];
  wire i2cStart = syncB[1] & pinPrev[1] & pinPrev[0] & ~syncB[0];
  wire i2cStop = syncB[1] & pinPrev[1] & ~pinPrev[0] & syncB[0];

  function [7:0] cfgReset;
    input [7:0] a;
    begin
      case (a)
        `APRC_REG_SYSTEM_CONTROL_ONE: cfgReset = `APRC_RST_SYS1;
        `APRC_REG_SYSTEM_CONTROL_TWO: cfgReset = `APRC_RST_SYS2;
        `APRC_REG_FORMAT: cfgReset = `APRC_RST_FORMAT;
        `APRC_REG_RATE: cfgReset = `APRC_RST_RATE;
        `APRC_REG_MASTER_VOL: cfgReset = `APRC_RST_MUTE;
        `APRC_REG_TONE_INDEX: cfgReset = `APRC_RST_TONE_INDEX;
        `APRC_REG_TONE_SET: cfgReset = `APRC_RST_TONE_SET;
        `APRC_REG_AM_CTRL: cfgReset = `APRC_RST_AM_CTRL;
        `APRC_REG_AM_FREQ_LO: cfgReset = 8'h00;
        `APRC_REG_AM_FREQ_HI: cfgReset = 8'h00;
        default: cfgReset = `APRC_RST_CHAN_VOL;
      endcase
    end
  endfunction

  function [7:0] regRead;
    input [7:0] a;
    begin
      if (a == `APRC_REG_GENERAL_STATUS) begin
        regRead = {DEVICE_ID, 3'b000, clipFlag};
      end else if (a == `APRC_REG_ERROR_STATUS) begin
        regRead = {3'b000, errPll, errSlip, errSck, errLr, valid};
      end else if (a >= `APRC_REG_SYSTEM_CONTROL_ONE && a <= `APRC_REG_AM_FREQ_HI) begin
        regRead = cfg[a];
      end else begin
        regRead = 8'h00;
      end
    end
  endfunction

  function [2:0] rateOf;
    input [11:0] p;
    begin
      if (p < `APRC_TH_192) rateOf = 3'd6;
      else if (p < `APRC_TH_176) rateOf = 3'd5;
      else if (p < `APRC_TH_96) rateOf = 3'd4;
      else if (p < `APRC_TH_88) rateOf = 3'd3;
      else if (p < `APRC_TH_48) rateOf = 3'd2;
      else if (p < `APRC_TH_44) rateOf = 3'd1;
      else rateOf = 3'd0;
    end
  endfunction

  // serial control slave; held idle while in reset
  always @(posedge clk) begin
    if (chipRst) begin
      iSt <= I_IDLE;
      iBit <= 4'h0;
      iSh <= 8'h00;
      iSub <= 8'h00;
      iTx <= 8'h00;
      iAck <= 1'b0;
      sdaDrive <= 1'b0;
      wrEn <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
    end else if (ce) begin
      wrEn <= 1'b0;
      if (i2cStart) begin
        iSt <= I_ADDR;
        iBit <= 4'h0;
        iAck <= 1'b0;
        sdaDrive <= 1'b0;
      end else if (i2cStop) begin
        iSt <= I_IDLE;
        iAck <= 1'b0;
        sdaDrive <= 1'b0;
      end else if (iSt != I_IDLE) begin
        if (sclRise) begin
          if (!iAck) begin
            iSh <= {iSh[6:0], sdaNow};
            iBit <= iBit + 4'h1;
          end else if (iSt == I_RD && !sdaDrive) begin
            // our own address ack is not a master ack
            if (sdaNow) begin
              iSt <= I_IDLE;
            end else begin
              iSub <= iSub + 8'h01;
              iTx <= regRead(iSub + 8'h01);
            end
          end
        end else if (sclFall) begin
          if (iAck) begin
            iAck <= 1'b0;
            iBit <= 4'h0;
            sdaDrive <= (iSt == I_RD) & ~iTx[7];
          end else if (iBit == 4'h8) begin
            iAck <= 1'b1;
            case (iSt)
              I_ADDR: begin
                sdaDrive <= (iSh[7:1] == I2C_ADDR);
                if (iSh[7:1] != I2C_ADDR) begin
                  iSt <= I_IDLE;
                end else if (iSh[0]) begin
                  iSt <= I_RD;
                  iTx <= regRead(iSub);
                end else begin
                  iSt <= I_SUB;
                end
              end
              I_SUB: begin
                iSub <= iSh;
                sdaDrive <= 1'b1;
                iSt <= I_WR;
              end
              I_WR: begin
                wrEn <= 1'b1;
                wrAddr <= iSub;
                wrData <= iSh;
                iSub <= iSub + 8'h01;
                sdaDrive <= 1'b1;
              end
              default: begin
                sdaDrive <= 1'b0;
              end
            endcase
          end else if (iSt == I_RD) begin
            sdaDrive <= ~iTx[3'd7 - iBit[2:0]];
          end
        end
      end
    end
  end

  // every control returns to its default on the same edge
  always @(posedge clk) begin
    if (chipRst) begin
      for (i = 3; i <= 16; i = i + 1) begin
        cfg[i] <= cfgReset(i[7:0]);
      end
    end else if (ce && wrEn && wrAddr >= `APRC_REG_SYSTEM_CONTROL_ONE &&
                 wrAddr <= `APRC_REG_AM_FREQ_HI) begin
      cfg[wrAddr] <= wrData;
    end
  end

  assign dcBlockEn = cfg[3][`APRC_SYS1_DCBLOCK];
  assign deemphSel = cfg[3][1:0];
  assign modLimit = cfg[4][2:0];
  assign supplyRange = cfg[4][5:4];
  assign amEnable = cfg[4][`APRC_SYS2_AM_EN];
  assign serialFormat = cfg[5];
  assign rateCtrl = cfg[6];
  assign toneIndex = cfg[12];
  assign toneSets = cfg[13];
  assign amCtrl = cfg[14];
  assign amTuned = {cfg[16], cfg[15]};
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chv
      assign chanVol[g*8 +: 8] = cfg[8 + g];
    end
  endgenerate

  // frame measurement in master clock cycles
  wire [11:0] perDiff = (perCnt > perPrev) ? perCnt - perPrev : perPrev - perCnt;
  wire perBad = (perCnt < `APRC_PER_MIN) | (perCnt > `APRC_PER_MAX);
  wire bitsBad = (bitsCnt != 8'h20) & (bitsCnt != 8'h30) & (bitsCnt != 8'h40);
  wire slipNow = (frameCnt == 2'd2) & (perDiff > `APRC_SLIP_MAX);
  wire lrTimeout = (perCnt == 12'hFFF);
  wire frameChk = lrRise & (frameCnt != 2'd0);
  wire setLr = (frameChk & perBad) | lrTimeout;
  wire setSck = frameChk & bitsBad;
  wire setSlip = lrRise & slipNow;
  wire setPll = ~syncB[4];
  wire clkBad = setLr | setSck | setSlip;
  wire clrErr = wrEn & (wrAddr == `APRC_REG_ERROR_STATUS);
  wire clrClip = wrEn & (wrAddr == `APRC_REG_GENERAL_STATUS);

  always @(posedge clk) begin
    if (chipRst) begin
      perCnt <= 12'h000;
      perPrev <= 12'h000;
      bitsCnt <= 8'h00;
      frameCnt <= 2'd0;
      rateKnown <= 1'b0;
      sampleRate <= 3'd0;
      errLr <= 1'b0;
      errSck <= 1'b0;
      errSlip <= 1'b0;
      errPll <= 1'b0;
      clipFlag <= 1'b0;
    end else if (ce) begin
      // set wins over a clearing write in the same cycle
      errLr <= (errLr & ~clrErr) | setLr;
      errSck <= (errSck & ~clrErr) | setSck;
      errSlip <= (errSlip & ~clrErr) | setSlip;
      errPll <= (errPll & ~clrErr) | setPll;
      clipFlag <= (clipFlag & ~clrClip) | clipEvent;
      if (lrRise) begin
        perCnt <= 12'h001;
        bitsCnt <= 8'h00;
        if (frameCnt != 2'd0) begin
          perPrev <= perCnt;
        end
        if (frameCnt != 2'd2) begin
          frameCnt <= frameCnt + 2'd1;
        end
        if (clkBad) begin
          rateKnown <= 1'b0;
        end else if (frameCnt == 2'd2) begin
          rateKnown <= 1'b1;
          sampleRate <= rateOf(perCnt);
        end
      end else begin
        if (!lrTimeout) begin
          perCnt <= perCnt + 12'h001;
        end else begin
          frameCnt <= 2'd0;
          rateKnown <= 1'b0;
        end
        if (sckRise && bitsCnt != 8'hFF) begin
          bitsCnt <= bitsCnt + 8'h01;
        end
      end
    end
  end

  wire muteReq = (cfg[7] == `APRC_RST_MUTE);
  always @* begin
    next_st = st;
    case (st)
      S_RESET: next_st = S_DETECT;
      S_DETECT: if (rateKnown) next_st = S_INIT;
      S_INIT: if (stCnt == INIT_CYC - 16'h0001) next_st = S_MUTED;
      S_MUTED: begin
        if (clkBad) next_st = S_DETECT;
        else if (!muteReq)
          next_st = (recov & cfg[3][`APRC_SYS1_HARD_UNMUTE]) ? S_RUN : S_START;
      end
      S_START: begin
        if (clkBad) next_st = S_DETECT;
        else if (muteReq) next_st = S_MUTED;
        else if (stCnt == START_CYC - 16'h0001) next_st = S_RUN;
      end
      S_RUN: begin
        if (clkBad) next_st = S_DETECT;
        else if (muteReq) next_st = S_MUTED;
      end
      default: next_st = S_RESET;
    endcase
  end

  always @(posedge clk) begin
    if (chipRst) begin
      st <= S_RESET;
      stCnt <= 16'h0000;
      recov <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      stCnt <= (next_st != st) ? 16'h0000 : stCnt + 16'h0001;
      if (next_st == S_DETECT && st != S_RESET) recov <= 1'b1;
      else if (next_st == S_RUN) recov <= 1'b0;
    end
  end

  // supply reference follows master volume scaled by the chosen range
  wire [1:0] supShift = (supplyRange == 2'd0) ? 2'd2 : (supplyRange == 2'd1) ? 2'd1 : 2'd0;
  wire [7:0] supLevel = ~(cfg[7] >> supShift);

  // outputs drop at once on the pin, no clock needed
  always @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      valid <= 1'b0;
      pwmP <= 4'h0;
      pwmM <= 4'h0;
      supplyPwm <= 1'b0;
      masterVol <= `APRC_RST_MUTE;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      pwmCnt <= 8'h00;
    end else if (chipRst) begin
      valid <= 1'b0;
      pwmP <= 4'h0;
      pwmM <= 4'h0;
      supplyPwm <= 1'b0;
      masterVol <= `APRC_RST_MUTE;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      pwmCnt <= 8'h00;
    end else if (ce) begin
      // valid leads switching, unless a hard unmute after recovery skips S_START, so the power stage starts quietly
      valid <= (st == S_START) | (st == S_RUN);
      pwmP <= (st == S_RUN) ? coreP : 4'h0;
      pwmM <= (st == S_RUN) ? coreM : 4'h0;
      pwmCnt <= pwmCnt + 8'h01;
      supplyPwm <= cfg[4][`APRC_SYS2_SUP_EN] & (pwmCnt < supLevel);
      masterVol <= cfg[7];
      sdaOe <= sdaDrive;
      sdaOut <= 1'b0;
    end
  end

  // dc blocker: y = x - x1 + y1 - y1/8192, corner near 0.86 Hz at 44.1 kHz
  always @(posedge clk) begin
    if (chipRst) sampleValid <= 1'b0;
    else if (ce) sampleValid <= sampleStrobe;
  end
  generate
    for (g = 0; g < 4; g = g + 1) begin : hp
      reg signed [23:0] xPrev;
      reg signed [38:0] acc;
      reg [23:0] y;
      wire signed [23:0] x = sampleIn[g*24 +: 24];
      wire signed [38:0] dx = ({{15{x[23]}}, x} - {{15{xPrev[23]}}, xPrev}) <<< `APRC_HP_SHIFT;
      wire signed [38:0] accNext = acc + dx - (acc >>> `APRC_HP_SHIFT);
      always @(posedge clk) begin
        if (chipRst) begin
          xPrev <= 24'h00_0000;
          acc <= 39'h00_0000_0000;
          y <= 24'h00_0000;
        end else if (ce && sampleStrobe) begin
          xPrev <= x;
          acc <= accNext;
          y <= dcBlockEn ? accNext[36:13] : x;
        end
      end
      assign sampleOut[g*24 +: 24] = y;
    end
  endgenerate
endmodule

// file: rtl/aprc_map.vh
// register map, field positions, reset values and timing counts
// assumes a 100 MHz clk that also stands in for the master clock
`ifndef APRC_MAP_VH
`define APRC_MAP_VH
`define APRC_REG_GENERAL_STATUS 8'h01
`define APRC_REG_ERROR_STATUS 8'h02
`define APRC_REG_SYSTEM_CONTROL_ONE 8'h03
`define APRC_REG_SYSTEM_CONTROL_TWO 8'h04
`define APRC_REG_FORMAT 8'h05
`define APRC_REG_RATE 8'h06
`define APRC_REG_MASTER_VOL 8'h07
`define APRC_REG_CHAN_VOL 8'h08
`define APRC_REG_TONE_INDEX 8'h0C
`define APRC_REG_TONE_SET 8'h0D
`define APRC_REG_AM_CTRL 8'h0E
`define APRC_REG_AM_FREQ_LO 8'h0F
`define APRC_REG_AM_FREQ_HI 8'h10
`define APRC_RST_SYS1 8'h90
`define APRC_RST_SYS2 8'h05
`define APRC_RST_FORMAT 8'hD3
`define APRC_RST_RATE 8'h05
`define APRC_RST_MUTE 8'hFF
`define APRC_RST_CHAN_VOL 8'h30
`define APRC_RST_TONE_INDEX 8'h12
`define APRC_RST_TONE_SET 8'h33
`define APRC_RST_AM_CTRL 8'h10
`define APRC_SYS1_DCBLOCK 7
`define APRC_SYS1_HARD_UNMUTE 4
`define APRC_SYS2_AM_EN 7
`define APRC_SYS2_SUP_EN 6
`define APRC_SLIP_MAX 12'h00A
`define APRC_PER_MIN 12'h01F4
`define APRC_PER_MAX 12'h0DAC
`define APRC_TH_192 12'h0220
`define APRC_TH_176 12'h0325
`define APRC_TH_96 12'h0440
`define APRC_TH_88 12'h0640
`define APRC_TH_48 12'h087F
`define APRC_TH_44 12'h0A8C
`define APRC_HP_SHIFT 13
`define APRC_CLK_MHZ 100
`define APRC_INIT_NS 1000
`define APRC_START_NS 2000
`define APRC_INIT_CYC ((`APRC_INIT_NS * `APRC_CLK_MHZ + 999) / 1000)
`define APRC_START_CYC ((`APRC_START_NS * `APRC_CLK_MHZ + 999) / 1000)
`endif

// file: bench/aprc_ctrl_asserts.sv
// port-level checks for the reset, status and control block
// assumes ce stays high; bound to the block from the bench top
`timescale 1ns/1ps
module aprc_ctrl_asserts (
  input wire clk,
  input wire srst,
  input wire resetN,
  input wire valid,
  input wire [3:0] pwmP,
  input wire [3:0] pwmM,
  input wire [3:0] coreP,
  input wire [3:0] coreM,
  input wire sdaOe,
  input wire [7:0] masterVol,
  input wire dcBlockEn,
  input wire [1:0] deemphSel,
  input wire [95:0] sampleIn,
  input wire sampleStrobe,
  input wire [95:0] sampleOut,
  input wire sampleValid
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst || !resetN);
  sequence s_quiet;
    !valid && pwmP == 4'h0 && pwmM == 4'h0 && !sdaOe && masterVol == 8'hFF;
  endsequence
  sequence s_held_low;
    !valid [*3];
  endsequence
  sequence s_run;
    valid [*8];
  endsequence
  property p_async_reset;
    disable iff (1'b0) !resetN |-> s_quiet;
  endproperty
  property p_sync_reset;
    disable iff (!resetN) srst |=> s_quiet;
  endproperty
  // release goes through the synchroniser, so no instant start
  property p_release;
    $rose(resetN) |-> s_held_low;
  endproperty
  property p_defaults;
    $fell(srst) |-> dcBlockEn && deemphSel == 2'h0 && masterVol == 8'hFF;
  endproperty
  property p_valid_gate;
    $rose(valid) |-> masterVol != 8'hFF;
  endproperty
  property p_valid_hold;
    $rose(valid) |=> s_run;
  endproperty
  property p_pwm_follow;
    (pwmP != 4'h0 || pwmM != 4'h0) |-> valid && pwmP == $past(coreP) && pwmM == $past(coreM);
  endproperty
  property p_bypass;
    !dcBlockEn && sampleStrobe |=> sampleValid && sampleOut == $past(sampleIn);
  endproperty
  a_async_reset: assert property (p_async_reset) else $error("outputs live in pin reset");
  a_sync_reset: assert property (p_sync_reset) else $error("outputs live after srst");
  a_release: assert property (p_release) else $error("valid too soon after release");
  a_defaults: assert property (p_defaults) else $error("control not at default");
  a_valid_gate: assert property (p_valid_gate) else $error("start while muted");
  a_valid_hold: assert property (p_valid_hold) else $error("start sequence cut short");
  a_pwm_follow: assert property (p_pwm_follow) else $error("pwm out of step with core");
  a_bypass: assert property (p_bypass) else $error("bypassed sample altered");
endmodule

// file: bench/aprc_i2c_host.sv
// i2c host model that configures the block over its control pins
// assumes sdaOe pulls the wire low; a pull-up holds it high otherwise
`timescale 1ns/1ps
module aprc_i2c_host #(
  parameter [6:0] ADDR = 7'h1B
) (
  input wire clk,
  input wire sdaOe,
  output reg sclPin,
  output wire sdaIn
);
  reg hostLow = 1'b0;
  reg ackOk = 1'b1;
  // pull-up: a released wire reads high, never the last value
  assign sdaIn = ~(hostLow | sdaOe);
  initial sclPin = 1'b1;
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // 16 clk phases keep well above the 8 clk minimum
  task automatic bitX(input logic d, output logic q);
    hostLow <= ~d;
    waitClk(8);
    sclPin <= 1'b1;
    waitClk(8);
    q = sdaIn;
    waitClk(8);
    sclPin <= 1'b0;
    waitClk(8);
  endtask
  task automatic byteX(input logic [7:0] tx, input logic expAck, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bitX(tx[i], rx[i]);
    bitX(1'b1, a);
    if (expAck) ackOk = ackOk & ~a;
  endtask
  task automatic startCond;
    hostLow <= 1'b0;
    waitClk(8);
    sclPin <= 1'b1;
    waitClk(8);
    hostLow <= 1'b1;
    waitClk(8);
    sclPin <= 1'b0;
    waitClk(8);
  endtask
  task automatic stopCond;
    hostLow <= 1'b1;
    waitClk(8);
    sclPin <= 1'b1;
    waitClk(8);
    hostLow <= 1'b0;
    waitClk(8);
  endtask
  task automatic writeReg(input logic [7:0] sub, input logic [7:0] data);
    logic [7:0] r;
    startCond();
    byteX({ADDR, 1'b0}, 1'b1, r);
    byteX(sub, 1'b1, r);
    byteX(data, 1'b1, r);
    stopCond();
  endtask
  // single byte read ends with a nack from the host
  task automatic readReg(input logic [7:0] sub, output logic [7:0] data);
    logic [7:0] r;
    startCond();
    byteX({ADDR, 1'b0}, 1'b1, r);
    byteX(sub, 1'b1, r);
    startCond();
    byteX({ADDR, 1'b1}, 1'b1, r);
    byteX(8'hFF, 1'b0, data);
    stopCond();
  endtask
  task automatic unmute;
    writeReg(8'h07, 8'h00);
  endtask
  task automatic quietMute;
    writeReg(8'h07, 8'hFF);
  endtask
endmodule

// file: bench/aprc_ctrl_tb_top.sv
// self-checking bench for the reset, status and control block
// assumes the checker and host model files are compiled first
`timescale 1ns/1ps
module aprc_ctrl_tb_top;
  localparam [3:0] ID = 4'hA; // arbitrary value
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg resetN = 1'b1;
  reg pllLock = 1'b1;
  reg lrclkPin = 1'b0;
  reg sclkPin = 1'b0;
  reg clipEvent = 1'b0;
  reg [3:0] coreP = 4'h0;
  reg [3:0] coreM = 4'h0;
  reg [95:0] sampleIn = 96'h0;
  reg sampleStrobe = 1'b0;
  reg linkRun = 1'b1;
  wire sclPin, sdaIn, sdaOe, valid, supplyPwm, dcBlockEn, amEnable, sampleValid;
  wire [95:0] sampleOut;
  wire [3:0] pwmP, pwmM;
  wire [7:0] masterVol, amCtrl, serialFormat, rateCtrl, toneIndex, toneSets;
  wire [31:0] chanVol;
  wire [1:0] deemphSel, supplyRange;
  wire [2:0] modLimit, sampleRate;
  wire [15:0] amTuned;
  logic [7:0] regModel [0:16];
  logic [31:0] rng = 32'h0001_2793;
  logic [7:0] rd;
  logic [3:0] capP;
  int bitCnt = 0;
  int cycles = 0;
  int mismatches = 0;
  int checks = 0;
  longint hpAcc = 0;
  int hpPrev = 0;
  int hpHold = 0;
  logic [23:0] hpExp = 24'h00_0000;
  logic hpOk = 1'b0;
  aprc_ctrl #(.DEVICE_ID(ID)) i_aprc_ctrl (.clk, .ce(1'b1), .srst, .resetN, .pllLock,
    .lrclkPin, .sclkPin, .sclPin, .sdaIn, .sdaOut(), .sdaOe, .clipEvent, .coreP, .coreM,
    .sampleIn, .sampleStrobe, .sampleOut, .sampleValid, .valid, .pwmP, .pwmM,
    .supplyPwm, .masterVol, .chanVol, .dcBlockEn, .deemphSel, .modLimit, .supplyRange,
    .amEnable, .amCtrl, .amTuned, .serialFormat, .rateCtrl, .toneIndex, .toneSets,
    .sampleRate);
  aprc_i2c_host i_aprc_i2c_host (.clk, .sdaOe, .sclPin, .sdaIn);
  always #5 clk = ~clk;
  // 64 bit clocks of 160 ns per frame; holds still while stopped
  // frame clock moves on the bit clock's falling edge, as serial audio does
  always begin
    #80;
    if (linkRun) begin
      sclkPin = ~sclkPin;
      if (!sclkPin) begin
        bitCnt = (bitCnt + 1) % 32;
        if (bitCnt == 0) lrclkPin = ~lrclkPin;
      end
    end
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  always @(posedge clk) begin
    rng = xorshift(rng);
    coreP <= rng[3:0];
    coreM <= rng[7:4];
    sampleIn <= {3{rng}};
    sampleStrobe <= (rng[11:8] == 4'h0);
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      conclude();
    end
  end
  // channel 0 filter model in a 39-bit q13 accumulator; skipped in reset and for two cycles after the reset pin releases
  always @(posedge clk) begin
    if (sampleValid && hpOk) check(sampleOut[23:0], hpExp);
    if (srst || !resetN || hpHold != 0) begin
      hpAcc = 0;
      hpPrev = 0;
      hpOk = 1'b0;
    end else if (sampleStrobe) begin
      hpAcc = hpAcc + (longint'(int'($signed(sampleIn[23:0])) - hpPrev) <<< 13) - (hpAcc >>> 13);
      hpAcc = (hpAcc <<< 25) >>> 25;
      hpPrev = int'($signed(sampleIn[23:0]));
      hpExp = regModel[3][7] ? hpAcc[36:13] : sampleIn[23:0];
      hpOk = (dcBlockEn === regModel[3][7]);
    end
    hpHold = !resetN ? 2 : ((hpHold > 0) ? hpHold - 1 : 0);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic loadDefaults;
    regModel = '{3: 8'h90, 4: 8'h05, 5: 8'hD3, 6: 8'h05, 7: 8'hFF, 8: 8'h30, 9: 8'h30,
      10: 8'h30, 11: 8'h30, 12: 8'h12, 13: 8'h33, 14: 8'h10, default: 8'h00};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_aprc_i2c_host.writeReg(a, d);
    if (a >= 8'h03 && a <= 8'h10) regModel[a] = d;
  endtask
  task automatic rdCheck(input logic [7:0] a);
    logic [7:0] d;
    i_aprc_i2c_host.readReg(a, d);
    check(d, regModel[a]);
  endtask
  task automatic checkOuts;
    check(dcBlockEn, regModel[3][7]);
    check(deemphSel, regModel[3][1:0]);
    check(supplyRange, regModel[4][5:4]);
    check({amEnable, modLimit}, {regModel[4][7], regModel[4][2:0]});
    check({serialFormat, rateCtrl}, {regModel[5], regModel[6]});
    check(masterVol, regModel[7]);
    check(chanVol, {regModel[11], regModel[10], regModel[9], regModel[8]});
    check({toneSets, toneIndex}, {regModel[13], regModel[12]});
    check({amTuned, amCtrl}, {regModel[16], regModel[15], regModel[14]});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    loadDefaults();
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    checkOuts();
    i_aprc_i2c_host.readReg(8'h01, rd);
    check(rd, {ID, 4'h0});
    rdCheck(8'h03);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h03, {rng[7:5], 1'b1, rng[3:2], i[1:0]});
      wr(8'h04, {1'b0, 1'b1, i[1:0], 1'b0, rng[2:0]});
      checkOuts();
      rdCheck(8'h03);
      rdCheck(8'h04);
    end
    wr(8'h11, 8'h5A);
    i_aprc_i2c_host.readReg(8'h11, rd);
    check(rd, 8'h00);
    wr(8'h03, 8'h10);
    repeat (64) @(posedge clk);
    wr(8'h03, 8'h90);
    $display("test controls done");
    i_aprc_i2c_host.unmute();
    regModel[7] = 8'h00;
    for (int n = 0; n < 400 && valid !== 1'b1; n++) @(posedge clk);
    check(valid, 1'b1);
    repeat (250) @(posedge clk);
    capP = coreP;
    @(negedge clk);
    check(pwmP, capP);
    for (int n = 0; n < 300 && supplyPwm !== 1'b1; n++) @(posedge clk);
    check(supplyPwm, 1'b1);
    wr(8'h04, 8'h05);
    rd = 8'h00;
    repeat (300) begin
      @(negedge clk);
      if (supplyPwm !== 1'b0) rd = 8'h01;
    end
    check(rd, 8'h00);
    $display("test unmute done");
    @(posedge clk);
    clipEvent <= 1'b1;
    @(posedge clk);
    clipEvent <= 1'b0;
    i_aprc_i2c_host.readReg(8'h01, rd);
    check(rd, {ID, 4'h1});
    wr(8'h01, rng[7:0]);
    i_aprc_i2c_host.readReg(8'h01, rd);
    check(rd, {ID, 4'h0});
    $display("test clip done");
    pllLock <= 1'b0;
    linkRun = 1'b0;
    repeat (5000) @(posedge clk);
    pllLock <= 1'b1;
    linkRun = 1'b1;
    repeat (6000) @(posedge clk);
    i_aprc_i2c_host.readReg(8'h02, rd);
    check({rd[4], rd[1]}, 2'b11);
    check(rd[0], valid);
    check(sampleRate, 3'd4);
    wr(8'h02, 8'h00);
    i_aprc_i2c_host.readReg(8'h02, rd);
    check(rd[4:1], 4'h0);
    check(i_aprc_i2c_host.ackOk, 1'b1);
    $display("test errors done");
    i_aprc_i2c_host.quietMute();
    regModel[7] = 8'hFF;
    check(valid, 1'b0);
    #3 resetN = 1'b0;
    #1;
    check({valid, pwmP, pwmM, sdaOe, masterVol}, {10'h000, 8'hFF});
    i_aprc_i2c_host.writeReg(8'h03, 8'h00);
    #3 resetN = 1'b1;
    repeat (5) @(posedge clk);
    loadDefaults();
    checkOuts();
    rdCheck(8'h03);
    $display("test reset pin done");
    conclude();
  end
endmodule
bind aprc_ctrl aprc_ctrl_asserts i_aprc_ctrl_asserts (.clk, .srst, .resetN, .valid, .pwmP,
  .pwmM, .coreP, .coreM, .sdaOe, .masterVol, .dcBlockEn, .deemphSel, .sampleIn,
  .sampleStrobe, .sampleOut, .sampleValid);
